// ---- rtl/spp_param_port.sv ----
// What this block does
// - four parameter pins are open-drain pull-downs with input samplers.
// - new values are latched in the output register, then driven to pins.
// - pins are sampled 11 to 13.5 us after new data reaches them.
// - with multiplex clear, returned bit is driven bit AND pin level.
// - with multiplex set, returned bit is the external pin level only.
// - every new parameter value is announced by a strobe pulse.
// - strobe pulse lasts 5 to 6 us.
// - bits driven low are valid 0.1 to 0.6 us before strobe fall.
// - released bits are high impedance 0.1 to 0.6 us before strobe fall.
// - in multiplex mode drivers go high impedance 0.1 to 0.6 us after strobe fall.
// - after reset the data port stays off until first parameter write.
// - reset or address deletion loads 0xF and releases all drivers.
// - forced defaults also get a strobe with normal lead and width.
// - in multiplex mode drivers switch off before input sampling.
// - multiplex flag comes from configuration; release only when set.
`timescale 1ns/10ps
`default_nettype none
`include "spp_regs.svh"

module spp_param_port
    import spp_pkg::*;
(
    // clock and reset
    input  wire logic     core_clk,
    input  wire logic     rstn,
    // configuration
    input  wire logic     slave_mode,
    input  wire logic     mux_param_cfg,
    // parameter writes from the network
    input  wire logic     param_wr_valid,
    input  wire spp_nib_t param_wr_data,
    output logic          param_wr_ready,
    input  wire logic     delete_req,
    // parameter pins, open drain
    input  wire spp_nib_t param_pins_in,
    output logic          param_pins_out,
    output spp_nib_t      param_pins_oe,
    output logic          parameter_strobe_n,
    // returned data and data port gate
    output logic          return_valid,
    output spp_nib_t      return_data,
    output logic          data_port_en
);
    localparam spp_cnt_t LEAD_C   = spp_cnt_t'(`SPP_LEAD_CYC);
    localparam spp_cnt_t STROBE_C = spp_cnt_t'(`SPP_STROBE_CYC);
    localparam spp_cnt_t HOLD_C   = spp_cnt_t'(`SPP_HOLD_CYC);
    localparam spp_cnt_t ACCEPT_C = spp_cnt_t'(`SPP_ACCEPT_CYC);

    spp_pin_if pif ();

    spp_state_t state_r;
    spp_state_t state_nxt;
    spp_cnt_t   cnt_r;
    spp_cnt_t   cnt_nxt;
    spp_nib_t   value_r;
    spp_nib_t   value_nxt;
    logic       def_pend_r;
    logic       def_pend_nxt;
    logic       drive_en_r;
    logic       drive_en_nxt;
    logic       mux_r;
    logic       strobe_n_r;
    logic       ret_valid_r;
    logic       dp_en_r;

    function automatic logic at(input spp_cnt_t n);
        at = (cnt_r == n);
    endfunction

    wire idle       = (state_r == SPP_IDLE);
    wire start_def  = idle && def_pend_r && slave_mode;
    wire start_wr   = param_wr_valid && param_wr_ready;
    wire start      = start_def || start_wr;
    wire lead_end   = (state_r == SPP_LEAD) && at(LEAD_C - 8'h01);
    wire strobe_end = (state_r == SPP_STROBE)
                      && at(LEAD_C + STROBE_C - 8'h01);
    wire release_pt = mux_r && (state_r == SPP_STROBE)
                      && at(LEAD_C + HOLD_C - 8'h01);
    // one point inside the acceptance window; partner holds levels there
    wire sample_pt  = (state_r == SPP_SETTLE)
                      && at(ACCEPT_C);

    // defaults win over writes; a new deletion in slave mode is never lost
    assign param_wr_ready = idle && slave_mode && !def_pend_r;
    assign def_pend_nxt   = (def_pend_r && !start_def)
                            || (delete_req && slave_mode);
    assign value_nxt      = start_def ? `SPP_DEFAULT_VALUE
                          : start_wr  ? param_wr_data
                          : value_r;
    assign drive_en_nxt   = !slave_mode ? 1'b0
                          : start       ? 1'b1
                          : release_pt  ? 1'b0
                          : drive_en_r;
    assign cnt_nxt        = idle ? '0 : cnt_r + 8'h01;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            SPP_IDLE:   if (start) state_nxt = SPP_LEAD;
            SPP_LEAD:   if (lead_end) state_nxt = SPP_STROBE;
            SPP_STROBE: if (strobe_end) state_nxt = SPP_SETTLE;
            SPP_SETTLE: if (sample_pt) state_nxt = SPP_IDLE;
            default:    state_nxt = SPP_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_r    <= SPP_IDLE;
            cnt_r      <= '0;
            def_pend_r <= 1'b1;
            value_r    <= `SPP_DEFAULT_VALUE;
        end else begin
            state_r    <= state_nxt;
            cnt_r      <= cnt_nxt;
            def_pend_r <= def_pend_nxt;
            value_r    <= value_nxt;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            drive_en_r  <= 1'b0;
            mux_r       <= 1'b0;
            strobe_n_r  <= 1'b1;
            ret_valid_r <= 1'b0;
            dp_en_r     <= 1'b0;
        end else begin
            drive_en_r  <= drive_en_nxt;
            if (start) begin
                mux_r <= mux_param_cfg;
            end
            strobe_n_r  <= (state_r != SPP_STROBE);
            ret_valid_r <= sample_pt;
            if (start_wr) begin
                dp_en_r <= 1'b1;
            end
        end
    end

    assign pif.value    = value_r;
    assign pif.drive_en = drive_en_r;
    assign pif.mux      = mux_r;
    assign pif.sample   = sample_pt;

    spp_pin_bank u_pins (
        .core_clk (core_clk),
        .rstn     (rstn),
        .ctl      (pif),
        .pins_in  (param_pins_in),
        .pins_out (param_pins_out),
        .pins_oe  (param_pins_oe)
    );

    assign parameter_strobe_n = strobe_n_r;
    assign return_valid       = ret_valid_r;
    assign return_data        = pif.ret_data;
    assign data_port_en       = dp_en_r;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    sequence seq_start;
        (state_r != SPP_IDLE) && $past(state_r == SPP_IDLE);
    endsequence

    sequence seq_fall;
        $fell(parameter_strobe_n);
    endsequence

    strobe_width_a: assert property (seq_fall |->
        (!parameter_strobe_n)[*8]
        ##42 !parameter_strobe_n ##1 parameter_strobe_n)
        else $error("strobe width not 50 cycles");

    strobe_lead_a: assert property (seq_start |->
        ##5 parameter_strobe_n ##1 !parameter_strobe_n)
        else $error("strobe not 5 cycles after drive start");

    oe_before_strobe_a: assert property (seq_fall |->
        (param_pins_oe == ~value_r)
        && (param_pins_oe == $past(param_pins_oe, 5)))
        else $error("pin drive not settled before strobe");

    release_hold_a: assert property ((seq_fall and mux_r) |->
        ##4 (param_pins_oe == ~value_r) ##1 (param_pins_oe == 4'h0))
        else $error("multiplex release not 5 cycles after strobe");

    accept_time_a: assert property (seq_start |->
        ##110 !return_valid ##1 return_valid)
        else $error("return sample not at acceptance point");

    wired_and_a: assert property (return_valid && !mux_r |->
        return_data == ($past(param_pins_in) & value_r))
        else $error("return data not wired AND");

    mux_return_a: assert property (return_valid && mux_r |->
        return_data == $past(param_pins_in))
        else $error("multiplex return not pin level");

    delete_default_a: assert property (delete_req && slave_mode |->
        ##[1:120] ((state_r == SPP_LEAD) && (value_r == 4'hF)))
        else $error("deletion default not applied");

    data_port_gate_a: assert property ($rose(data_port_en) |->
        $past(param_wr_valid && param_wr_ready))
        else $error("data port enabled without parameter write");

    non_slave_off_a: assert property (!slave_mode |->
        ##2 param_pins_oe == 4'h0)
        else $error("pins driven outside slave mode");

    write_latch_a: assert property (start_wr |=>
        value_r == $past(param_wr_data))
        else $error("written value not latched");

    drive_value_a: assert property (seq_start |->
        ##1 (param_pins_oe == ~value_r))
        else $error("latched value not driven to pins");

    default_strobe_a: assert property (start_def |=>
        ##5 parameter_strobe_n ##1 !parameter_strobe_n)
        else $error("default event without normal strobe");
endmodule

`default_nettype wire

// ---- rtl/spp_pin_bank.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "spp_regs.svh"

module spp_pin_bank
    import spp_pkg::*;
(
    // clock and reset
    input  wire logic     core_clk,
    input  wire logic     rstn,
    // sequencer side
    spp_pin_if.pins       ctl,
    // open-drain pins
    input  wire spp_nib_t pins_in,
    output logic          pins_out,
    output spp_nib_t      pins_oe
);
    spp_nib_t oe_r;
    spp_nib_t ret_r;
    spp_nib_t oe_nxt;
    spp_nib_t ret_nxt;

    // pull-down only: a one bit is released, never driven high
    assign pins_out = 1'b0;
    assign oe_nxt   = ctl.drive_en ? ~ctl.value : '0;
    assign ret_nxt  = ctl.mux ? pins_in
                              : (pins_in & ctl.value);
    assign pins_oe      = oe_r;
    assign ctl.ret_data = ret_r;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            oe_r <= '0;
        end else begin
            oe_r <= oe_nxt;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ret_r <= `SPP_DEFAULT_VALUE;
        end else if (ctl.sample) begin
            ret_r <= ret_nxt;
        end
    end
endmodule

`default_nettype wire

// ---- rtl/spp_pin_if.sv ----
`timescale 1ns/10ps
`default_nettype none

interface spp_pin_if;
    import spp_pkg::*;
    spp_nib_t value;
    logic     drive_en;
    logic     mux;
    logic     sample;
    spp_nib_t ret_data;

    modport ctrl (
        output value,
        output drive_en,
        output mux,
        output sample,
        input  ret_data
    );

    modport pins (
        input  value,
        input  drive_en,
        input  mux,
        input  sample,
        output ret_data
    );
endinterface

`default_nettype wire

// ---- rtl/spp_pkg.sv ----
`include "spp_regs.svh"

package spp_pkg;
    typedef logic [`SPP_PINS-1:0] spp_nib_t;
    typedef logic [`SPP_CNT_W-1:0] spp_cnt_t;
    typedef enum logic [1:0] {
        SPP_IDLE,
        SPP_LEAD,
        SPP_STROBE,
        SPP_SETTLE
    } spp_state_t;
endpackage

// ---- rtl/spp_regs.svh ----
`ifndef SPP_REGS_SVH
`define SPP_REGS_SVH

// core clock period
`define SPP_CLK_PERIOD_NS  100

// pin count and default parameter value
`define SPP_PINS           4
`define SPP_DEFAULT_VALUE  4'hF
`define SPP_CNT_W          8

// lead of data/release before strobe fall, allowed 100..600 ns
`define SPP_LEAD_NS        500
`define SPP_LEAD_CYC       (`SPP_LEAD_NS / `SPP_CLK_PERIOD_NS)

// strobe width, allowed 5000..6000 ns, least value rounded up
`define SPP_STROBE_MIN_NS  5000
`define SPP_STROBE_CYC     ((`SPP_STROBE_MIN_NS + `SPP_CLK_PERIOD_NS - 1) \
                            / `SPP_CLK_PERIOD_NS)

// driver release after strobe fall in multiplex mode, 100..600 ns
`define SPP_HOLD_NS        500
`define SPP_HOLD_CYC       (`SPP_HOLD_NS / `SPP_CLK_PERIOD_NS)

// input acceptance after data reaches the pins, 11000..13500 ns
`define SPP_ACCEPT_MIN_NS  11000
`define SPP_ACCEPT_CYC     ((`SPP_ACCEPT_MIN_NS + `SPP_CLK_PERIOD_NS - 1) \
                            / `SPP_CLK_PERIOD_NS)

`endif

// ---- verif/spp_param_port_tb.sv ----
`timescale 1ns/10ps
`default_nettype none

module spp_param_port_tb;
    import spp_pkg::*;
    logic       core_clk, rstn, slave_mode, mux_cfg, wr_valid, del_req;
    logic       ready, strobe_n, ret_valid, dpe, pins_out;
    spp_nib_t   wr_data, pins_in, oe, ret_data, ret_set, oe1, oe11, rdat;
    logic [7:0] fall_i, rise_i, rv_i;
    int         error_cnt, n_checks;

    spp_param_port dut_u (.core_clk(core_clk), .rstn(rstn),
        .slave_mode(slave_mode), .mux_param_cfg(mux_cfg),
        .param_wr_valid(wr_valid), .param_wr_data(wr_data),
        .param_wr_ready(ready), .delete_req(del_req),
        .param_pins_in(pins_in), .param_pins_out(pins_out),
        .param_pins_oe(oe),
        .parameter_strobe_n(strobe_n), .return_valid(ret_valid),
        .return_data(ret_data), .data_port_en(dpe));

    spp_pin_model far_u (.strobe_n(strobe_n), .oe(oe), .pins(pins_in),
        .ret_set(ret_set));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // entered at the falling edge after the taking edge
    task automatic watch(spp_nib_t d, logic m, spp_nib_t ext);
        logic [7:0] i;
        fall_i = 8'h00;
        rise_i = 8'h00;
        rv_i = 8'h00;
        for (i = 8'h01; i < 8'h74; i++) begin
            @(negedge core_clk);
            if (strobe_n === 1'b0 && fall_i == 8'h00) fall_i = i;
            if (strobe_n === 1'b1 && fall_i != 0 && rise_i == 0) rise_i = i;
            if (ret_valid === 1'b1) rv_i = i;
            if (ret_valid === 1'b1) rdat = ret_data;
            if (i == 8'h01) oe1 = oe;
            if (i == 8'h0B) oe11 = oe;
        end
        check("oe after take", 8'(oe1), {4'h0, ~d});
        check("strobe lead", fall_i, 8'h06);
        check("strobe width", rise_i - fall_i, 8'h32);
        check("sample edge", rv_i, 8'h6F);
        check("oe in hold", 8'(oe11), {4'h0, (m ? 4'h0 : ~d)});
        check("return", 8'(rdat), 8'(m ? ext : ext & d));
    endtask

    task automatic wr(spp_nib_t d, logic m, spp_nib_t ext);
        int n;
        n = 0;
        mux_cfg = m;
        ret_set = ext;
        wr_data = d;
        wr_valid = 1'b1;
        while (ready !== 1'b1 && n < 300) begin
            @(negedge core_clk);
            n++;
        end
        check("ready in time", 8'(ready), 8'h01);
        @(negedge core_clk);
        wr_valid = 1'b0;
        watch(d, m, ext);
    endtask

    task automatic t_reset();
        ret_set = 4'h6;
        rstn = 1'b0;
        repeat (6) @(negedge core_clk);
        check("oe in reset", 8'(oe), 8'h00);
        check("pin drive level", 8'(pins_out), 8'h00);
        check("return in reset", 8'(ret_data), 8'h0F);
        rstn = 1'b1;
        @(negedge core_clk);
        watch(4'hF, 1'b0, 4'h6);
        check("port enable", 8'(dpe), 8'h00);
    endtask

    task automatic t_plain();
        wr(4'h0, 1'b0, 4'hC);
        check("port enable", 8'(dpe), 8'h01);
        wr(4'h5, 1'b0, 4'hC);
        wr(4'hA, 1'b0, 4'h7);
        wr(4'h3, 1'b0, 4'hF);
    endtask

    task automatic t_mux();
        wr(4'h0, 1'b1, 4'hA);
        wr(4'h5, 1'b1, 4'h3);
    endtask

    task automatic t_delete();
        mux_cfg = 1'b1;
        ret_set = 4'h9;
        del_req = 1'b1;
        @(negedge core_clk);
        del_req = 1'b0;
        // pending default is taken one edge after the deletion call
        @(negedge core_clk);
        watch(4'hF, 1'b1, 4'h9);
    endtask

    // the port must ignore writes and deletions outside slave mode
    task automatic t_no_slave();
        wr(4'h0, 1'b0, 4'hF);
        slave_mode = 1'b0;
        wr_valid = 1'b1;
        del_req = 1'b1;
        @(negedge core_clk);
        del_req = 1'b0;
        repeat (20) @(negedge core_clk);
        check("ready off", 8'(ready), 8'h00);
        check("strobe off", 8'(strobe_n), 8'h01);
        check("oe off", 8'(oe), 8'h00);
        wr_valid = 1'b0;
    endtask

    initial begin
        rstn = 1'b0;
        slave_mode = 1'b1;
        mux_cfg = 1'b0;
        wr_valid = 1'b0;
        wr_data = 4'h0;
        del_req = 1'b0;
        ret_set = 4'hF;
        error_cnt = 0;
        n_checks = 0;
        t_reset();
        $display("test reset default done");
        t_plain();
        $display("test plain writes done");
        t_mux();
        $display("test multiplex writes done");
        t_delete();
        $display("test deletion done");
        t_no_slave();
        $display("test not slave done");
        report_and_stop();
    end

    // about three times the expected run
    initial begin
        #300000;
        error_cnt++;
        report_and_stop();
    end
endmodule

`default_nettype wire

// ---- verif/spp_pin_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module spp_pin_model
    import spp_pkg::*;
(
    // pins as seen by the external logic
    input  wire logic     strobe_n,
    input  wire spp_nib_t oe,
    output spp_nib_t      pins,
    // return value the external logic will place
    input  wire spp_nib_t ret_set
);
    spp_nib_t held;

    initial held = 4'hF;

    // placed right after the strobe, kept until the next strobe
    always @(posedge strobe_n) held = ret_set;

    // pull-up on every pin: low when either side pulls down
    assign pins = ~oe & held;
endmodule

`default_nettype wire
